// ===== include/pfs_pkg.sv
`default_nettype none
package pfs_pkg;
  localparam int unsigned NPIN      = 6;
  localparam int unsigned DBG_PIN   = 4;
  localparam int unsigned RST_PIN   = 5;

  // Avalon byte addresses of the control words
  localparam logic [4:0] OFF_OPT    = 5'h00;
  localparam logic [4:0] OFF_PULL   = 5'h04;
  localparam logic [4:0] OFF_SLEW   = 5'h08;
  localparam logic [4:0] OFF_DRIVE  = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_FORCE  = 5'h14;

  // Field positions
  localparam int unsigned OPT_DPE_BIT   = 0;
  localparam int unsigned OPT_RESET_PIN_ENABLE_BIT = 1;
  localparam int unsigned FORCE_BIT     = 0;

  // Reset values
  localparam logic [5:0] PULL_RST  = 6'h00;
  localparam logic [5:0] SLEW_RST  = 6'h10;
  localparam logic [5:0] DRIVE_RST = 6'h00;

  localparam logic [3:0]  RST_HOLD_CYC = 4'h8;
  localparam logic [3:0]  BIT_CYCLES   = 4'hf;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;

  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_BGND  = 2'b10
  } pfs_mode_t;

  typedef struct packed {
    logic [5:0] oe;
    logic [5:0] out;
    logic [5:0] pull_en;
    logic [5:0] pull_dn;
    logic [5:0] slew;
    logic [5:0] drive;
  } pfs_pad_t;
endpackage
`default_nettype wire

// ===== rtl/pfs_pin_select.sv
`timescale 1ns/1ns
`default_nettype none
module pfs_pin_select
  import pfs_pkg::*;
(
  input  wire logic        core_clk,          // 250 MHz bus clock
  input  wire logic        rstn,              // Power-on reset, active low
  input  wire logic [4:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [31:0] avs_writedata,     // Write data
  input  wire logic [3:0]  avs_byteenable,    // Byte lanes
  output logic      [31:0] avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall
  input  wire logic [5:0]  pin_in,            // Pad levels, asynchronous
  input  wire logic [5:0]  port_dir,          // Port direction, 1 = output
  input  wire logic [5:0]  port_out,          // Port data
  input  wire logic [5:0]  periph_oe,         // Alternative function drives
  input  wire logic [5:0]  periph_out,        // Alternative function data
  input  wire logic [5:0]  adc_en,            // Converter owns pin
  input  wire logic [5:0]  cmp_en,            // Second analog module owns pin
  input  wire logic [5:0]  rise_sel,          // Rising-edge interrupt selected
  input  wire logic        dbg_drive_low,     // Debug controller pulls line low
  input  wire logic        dbg_speedup,       // Debug controller speedup pulse
  output pfs_pad_t         pad_r,             // Pad controls
  output logic      [5:0]  pin_level_r,       // Synchronised pad levels
  output logic      [5:0]  adc_conn_r,        // Pin routed to converter
  output logic      [5:0]  cmp_conn_r,        // Pin routed to second analog
  output logic             dbg_rx_r,          // Debug line level
  output logic             dbg_bit_tick_r,    // One pulse per debug bit time
  output logic             ext_reset_req_r,   // External reset pin asserted
  output logic             core_rst_n_r,      // Internal reset, active low
  output pfs_mode_t        mode_r,            // Operating mode
  output logic      [15:0] vector_addr_r      // Reset vector address
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta_r, rst_n_s;
  logic [5:0] pin_meta_r, pin_s;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      pin_meta_r <= 6'h3f;
      pin_s      <= 6'h3f;
    end
    else
    begin
      pin_meta_r <= pin_in;
      pin_s      <= pin_meta_r;
    end
  end

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Register file and reset sequencing
  // ----------------------------------------------------------------
  logic        dpe_r, dpe_nxt, reset_pin_enable_r, reset_pin_enable_nxt;
  logic [5:0]  pull_r, pull_nxt, slew_r, slew_nxt, drive_r, drive_nxt;
  logic [3:0]  hold_r, hold_nxt;
  logic        in_rst_r, por_r, por_nxt, qual_r, qual_nxt;
  pfs_mode_t   mode_nxt;
  logic [15:0] vec_nxt;
  logic        wait_nxt, ext_nxt;
  logic [31:0] rdata_nxt;
  logic        req, wr_go, rel, hold_act;

  assign req      = avs_read | avs_write;
  assign wr_go    = avs_write & !avs_waitrequest & avs_byteenable[0];
  assign hold_act = (hold_r != 4'h0);
  assign rel      = in_rst_r & !hold_act;

  always_comb
  begin
    dpe_nxt   = dpe_r;
    reset_pin_enable_nxt = reset_pin_enable_r;
    pull_nxt  = pull_r;
    slew_nxt  = slew_r;
    drive_nxt = drive_r;
    hold_nxt  = hold_act ? hold_r - 4'h1 : hold_r;
    por_nxt   = por_r;
    qual_nxt  = qual_r;
    mode_nxt  = mode_r;
    vec_nxt   = vector_addr_r;
    ext_nxt   = reset_pin_enable_r & !pin_s[RST_PIN];
    wait_nxt  = !(req & avs_waitrequest);
    rdata_nxt = avs_readdata;
    if (avs_read & avs_waitrequest)
    begin
      rdata_nxt = 32'h0;
      unique case (avs_address)
        OFF_OPT:    rdata_nxt[1:0] = {reset_pin_enable_r, dpe_r};
        OFF_PULL:   rdata_nxt[5:0] = pull_r;
        OFF_SLEW:   rdata_nxt[5:0] = slew_r;
        OFF_DRIVE:  rdata_nxt[5:0] = drive_r;
        OFF_STATUS: rdata_nxt[7:0] = {pin_s, mode_r};
        default:    rdata_nxt = 32'h0;
      endcase
    end
    if (wr_go)
    begin
      // Per-pin bits, untouched by the port registers
      if (hit(avs_address, OFF_OPT))
      begin
        dpe_nxt = avs_writedata[OPT_DPE_BIT];
        // Write-once: only power-on clears it
        reset_pin_enable_nxt = reset_pin_enable_r | avs_writedata[OPT_RESET_PIN_ENABLE_BIT];
      end
      if (hit(avs_address, OFF_PULL))
        pull_nxt = avs_writedata[5:0];
      if (hit(avs_address, OFF_SLEW))
        slew_nxt = avs_writedata[5:0];
      if (hit(avs_address, OFF_DRIVE))
        drive_nxt = avs_writedata[5:0];
      if (hit(avs_address, OFF_FORCE) && avs_writedata[FORCE_BIT])
      begin
        hold_nxt = RST_HOLD_CYC;
        qual_nxt = 1'b1;
      end
    end
    if (ext_reset_req_r && !hold_act)
      hold_nxt = RST_HOLD_CYC;
    if (hold_act)
    begin
      // Every reset restores pin defaults
      dpe_nxt   = 1'b1;
      pull_nxt  = PULL_RST;
      slew_nxt  = SLEW_RST;
      drive_nxt = DRIVE_RST;
      mode_nxt  = MODE_RESET;
    end
    if (rel)
    begin
      // Sampled once here, then held until the next reset
      if (qual_r && !pin_s[DBG_PIN])
        mode_nxt = MODE_BGND;
      else
        mode_nxt = MODE_RUN;
      vec_nxt = RESET_VECTOR;
      if (por_r && !pin_s[DBG_PIN])
        reset_pin_enable_nxt = 1'b1;
      por_nxt  = 1'b0;
      qual_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      dpe_r           <= 1'b1;
      reset_pin_enable_r         <= 1'b0;
      pull_r          <= PULL_RST;
      slew_r          <= SLEW_RST;
      drive_r         <= DRIVE_RST;
      hold_r          <= RST_HOLD_CYC;
      in_rst_r        <= 1'b1;
      por_r           <= 1'b1;
      qual_r          <= 1'b1;
      mode_r          <= MODE_RESET;
      vector_addr_r   <= 16'h0000;
      ext_reset_req_r <= 1'b0;
      core_rst_n_r    <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      dpe_r           <= dpe_nxt;
      reset_pin_enable_r         <= reset_pin_enable_nxt;
      pull_r          <= pull_nxt;
      slew_r          <= slew_nxt;
      drive_r         <= drive_nxt;
      hold_r          <= hold_nxt;
      in_rst_r        <= hold_act;
      por_r           <= por_nxt;
      qual_r          <= qual_nxt;
      mode_r          <= mode_nxt;
      vector_addr_r   <= vec_nxt;
      ext_reset_req_r <= ext_nxt;
      core_rst_n_r    <= !hold_act;
      avs_waitrequest <= wait_nxt;
      avs_readdata    <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin function priority and pad controls
  // ----------------------------------------------------------------
  pfs_pad_t   pad_nxt;
  logic [5:0] analog;
  logic       tick_nxt;
  logic [3:0] div_r, div_nxt;

  assign analog = adc_en | cmp_en;

  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      // Port first, alternative function overrides it
      pad_nxt.oe[i]  = port_dir[i];
      pad_nxt.out[i] = port_out[i];
      if (periph_oe[i])
      begin
        pad_nxt.oe[i]  = 1'b1;
        pad_nxt.out[i] = periph_out[i];
      end
      if (analog[i] || i == RST_PIN)
        pad_nxt.oe[i] = 1'b0;
      // Drivers win over the pullup
      pad_nxt.pull_en[i] = pull_r[i] & !pad_nxt.oe[i] & !analog[i];
      // Limiting an input edge is meaningless
      pad_nxt.slew[i]  = slew_r[i] & pad_nxt.oe[i];
      pad_nxt.drive[i] = drive_r[i];
    end
    if (dpe_r)
    begin
      // Open drain, driven high only for speedup pulses
      pad_nxt.oe[DBG_PIN]      = dbg_drive_low | dbg_speedup;
      pad_nxt.out[DBG_PIN]     = dbg_speedup;
      pad_nxt.pull_en[DBG_PIN] = 1'b1;
      pad_nxt.slew[DBG_PIN]    = 1'b0;
    end
    // Only the pull device flips, not its enable
    pad_nxt.pull_dn = pad_nxt.pull_en & rise_sel;
    if (dpe_r)
      pad_nxt.pull_dn[DBG_PIN] = 1'b0;
    // The bit clock runs only while the debug pin is selected
    div_nxt  = dpe_r ? div_r + 4'h1 : 4'h0;
    tick_nxt = dpe_r & (div_r == BIT_CYCLES);
  end

  always_ff @(posedge core_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      pad_r          <= '0;
      pin_level_r    <= 6'h00;
      adc_conn_r     <= 6'h00;
      cmp_conn_r     <= 6'h00;
      dbg_rx_r       <= 1'b1;
      div_r          <= 4'h0;
      dbg_bit_tick_r <= 1'b0;
    end
    else
    begin
      pad_r          <= pad_nxt;
      pin_level_r    <= pin_s;
      adc_conn_r     <= adc_en;
      cmp_conn_r     <= cmp_en;
      dbg_rx_r       <= pin_s[DBG_PIN] | !dpe_r;
      div_r          <= div_nxt;
      dbg_bit_tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_s);

  property p_bgnd_entry;
    rel && qual_r && !pin_s[DBG_PIN] |=> mode_r == MODE_BGND;
  endproperty
  a_bgnd_entry: assert property (p_bgnd_entry) else $error("background mode not entered");

  property p_run_entry;
    rel && pin_s[DBG_PIN] |=> mode_r == MODE_RUN && vector_addr_r == RESET_VECTOR;
  endproperty
  a_run_entry: assert property (p_run_entry) else $error("run mode not entered");

  property p_dpe_reset;
    hold_act |=> dpe_r;
  endproperty
  a_dpe_reset: assert property (p_dpe_reset) else $error("debug pin enable not set by reset");

  property p_dbg_pull;
    dpe_r |=> pad_r.pull_en[DBG_PIN] && !pad_r.pull_dn[DBG_PIN];
  endproperty
  a_dbg_pull: assert property (p_dbg_pull) else $error("debug pullup missing");

  property p_pull_off_drive;
    port_dir[0] || periph_oe[0] |=> !pad_r.pull_en[0] && (pad_r.oe[0] == !$past(analog[0]));
  endproperty
  a_pull_off_drive: assert property (p_pull_off_drive) else $error("pullup on a driven pin");

  property p_pull_off_analog;
    adc_en[1] |=> !pad_r.pull_en[1] && !pad_r.oe[1] && adc_conn_r[1];
  endproperty
  a_pull_off_analog: assert property (p_pull_off_analog) else $error("pullup on analog pin");

  property p_pulldown;
    pad_r.pull_dn[2] |-> pad_r.pull_en[2] && $past(rise_sel[2]);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown without rising edge");

  property p_slew_input;
    !pad_r.oe[3] |-> !pad_r.slew[3];
  endproperty
  a_slew_input: assert property (p_slew_input) else $error("slew on input pin");

  property p_priority;
    periph_oe[0] && !analog[0] |=> pad_r.out[0] == $past(periph_out[0]);
  endproperty
  a_priority: assert property (p_priority) else $error("port overrides peripheral");

  property p_reset_pin_enable_sticky;
    reset_pin_enable_r |=> reset_pin_enable_r;
  endproperty
  a_reset_pin_enable_sticky: assert property (p_reset_pin_enable_sticky) else $error("reset pin enable lost");

  property p_bit_tick;
    dbg_bit_tick_r && dpe_r |=> !dbg_bit_tick_r [*8];
  endproperty
  a_bit_tick: assert property (p_bit_tick) else $error("bit tick too frequent");

  property p_mode_held;
    !hold_act && !rel && mode_r != MODE_RESET |=> $stable(mode_r);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed outside reset");

  property p_bus_answer;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus not answered");

  c_bgnd:  cover property (rel && qual_r && !pin_s[DBG_PIN]);
  c_run:   cover property (rel && pin_s[DBG_PIN]);
  c_force: cover property (wr_go && hit(avs_address, OFF_FORCE));
  c_pdn:   cover property (pad_r.pull_dn[0]);

endmodule
`default_nettype wire

// ===== bench/pfs_dbg_host.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Debug host model on the mode-select line
// ------------------------------------------------
module pfs_dbg_host
(
  input  wire logic core_clk,  // Bus clock
  input  wire logic hold_low,  // Host pulls the line low
  input  wire logic dev_oe,    // Device drives the line
  input  wire logic dev_out,   // Device drive level
  input  wire logic dev_pull,  // Device pull enabled
  input  wire logic dev_dn,    // Device pull is a pulldown
  output logic      line       // Resolved line level
);
  logic last_r = 1'b0;
  logic hold_q_r = 1'b0;
  logic boost_r = 1'b0;

  always_ff @(posedge core_clk)
  begin
    hold_q_r <= hold_low;
    boost_r  <= hold_q_r & ~hold_low;
    last_r   <= line;
  end

  // Open drain: any low driver wins; a line nobody holds wanders
  always_comb
  begin
    if (hold_low || (dev_oe && !dev_out))
      line = 1'b0;
    else if (boost_r || dev_oe)
      line = 1'b1;
    else if (dev_pull)
      line = ~dev_dn;
    else
      line = ~last_r;
  end
endmodule
`default_nettype wire

// ===== bench/test_pin_function_and_mode_select.sv
`timescale 1ns/1ns
`default_nettype none
module test_pin_function_and_mode_select;
  import pfs_pkg::*;
  logic        core_clk, rstn, avs_read, avs_write, hold_low, dbg_drive_low, dbg_speedup, line4;
  logic        avs_waitrequest, dbg_rx_r, dbg_bit_tick_r, ext_reset_req_r, core_rst_n_r;
  logic [3:0]  avs_byteenable;
  logic [4:0]  avs_address;
  logic [5:0]  pin_bus, port_dir, port_out, periph_oe, periph_out, adc_en, cmp_en, rise_sel;
  logic [5:0]  pin_level_r, adc_conn_r, cmp_conn_r;
  logic [15:0] vector_addr_r;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [63:0] note;
  logic [63:0] notes[$];
  pfs_pad_t    pad_r;
  pfs_mode_t   mode_r;
  int          mismatches, num_checks, cycles, n;
  wire  [5:0]  pin_in = {pin_bus[5], line4, pin_bus[3:0]};

  pfs_pin_select pfs_pin_select_inst (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .port_dir,
    .port_out, .periph_oe, .periph_out, .adc_en, .cmp_en, .rise_sel, .dbg_drive_low,
    .dbg_speedup, .pad_r, .pin_level_r, .adc_conn_r, .cmp_conn_r, .dbg_rx_r, .dbg_bit_tick_r,
    .ext_reset_req_r, .core_rst_n_r, .mode_r, .vector_addr_r);

  pfs_dbg_host pfs_dbg_host_inst (.core_clk, .hold_low, .dev_oe(pad_r.oe[4]),
    .dev_out(pad_r.out[4]), .dev_pull(pad_r.pull_en[4]), .dev_dn(pad_r.pull_dn[4]), .line(line4));

  // ------------------------------------------------
  // Clock, timeout and read-data monitor
  // ------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // Each note carries a mask in its upper half so status reads ignore pin bits
  always @(posedge core_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0)
    begin
      note = notes.pop_front();
      check("readdata", note[31:0], avs_readdata & note[63:32]);
    end

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Holds the request until waitrequest is seen low; the bench timeout ends a hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    notes.push_back({m, e});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic wait_core(input logic lvl);
    int k;
    k = 0;
    while (core_rst_n_r !== lvl && k < 200)
    begin
      @(posedge core_clk);
      k++;
    end
    check("core_rst_n_r", {31'h0, lvl}, {31'h0, core_rst_n_r});
  endtask

  task automatic por(input logic low);
    hold_low <= low;
    rstn     <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    wait_core(1'b1);
    @(posedge core_clk);
  endtask

  task automatic pads();
    logic [31:0] r, q;
    logic [5:0]  an, drv, pe;
    r = xs(seed);
    q = xs(r);
    seed = q;
    bus(1'b1, OFF_PULL, {26'h0, r[5:0]}, 4'hf);
    bus(1'b1, OFF_SLEW, {26'h0, r[11:6]}, 4'hf);
    bus(1'b1, OFF_DRIVE, {26'h0, r[17:12]}, 4'hf);
    {port_dir, port_out, periph_oe, periph_out, adc_en, cmp_en, rise_sel} <= {q, r[27:18]};
    pin_bus[3:0] <= q[3:0];
    repeat (4) @(posedge core_clk);
    an  = adc_en | cmp_en;
    drv = (port_dir | periph_oe) & ~an & 6'h1f;
    pe  = r[5:0] & ~drv & ~an;
    check("oe", drv, pad_r.oe);
    check("out", ((periph_oe & periph_out) | (~periph_oe & port_out)) & drv, pad_r.out & drv);
    check("pull_en", pe, pad_r.pull_en);
    check("pull_dn", pe & rise_sel, pad_r.pull_dn);
    check("slew", r[11:6] & drv, pad_r.slew);
    check("drive", r[17:12], pad_r.drive);
    check("analog", {adc_en, cmp_en}, {adc_conn_r, cmp_conn_r});
    check("pin_level", {28'h0, q[3:0]}, {28'h0, pin_level_r[3:0]});
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    hold_low = 1'b1;
    {avs_read, avs_write, dbg_drive_low, dbg_speedup} = 4'h0;
    {port_dir, port_out, periph_oe, periph_out, adc_en, cmp_en, rise_sel} = 42'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    pin_bus = 6'h3f;
    seed = 32'h0d15;
    {cycles, mismatches, num_checks} = {32'd0, 32'd0, 32'd0};
    por(1'b1);
    check("mode", MODE_BGND, mode_r);
    rd(OFF_OPT, 32'hffffffff, 32'h3);
    check("dbg_rx", 32'h0, dbg_rx_r);
    hold_low <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("dbg_rx", 32'h1, dbg_rx_r);
    check("pull4", 32'h1, pad_r.pull_en[4]);
    dbg_speedup <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("speedup", 32'h3, {pad_r.oe[4], pad_r.out[4]});
    dbg_speedup   <= 1'b0;
    dbg_drive_low <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("drive_low", 32'h2, {pad_r.oe[4], pad_r.out[4]});
    dbg_drive_low <= 1'b0;
    repeat (4) @(posedge core_clk);
    n = 0;
    while (dbg_bit_tick_r !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    n = 1;
    while (dbg_bit_tick_r !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    check("bit_time", 32'd16, n);
    pin_bus[5] <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("ext_reset", 32'h1, ext_reset_req_r);
    pin_bus[5] <= 1'b1;
    wait_core(1'b0);
    wait_core(1'b1);
    check("mode", MODE_RUN, mode_r);
    rd(OFF_OPT, 32'hffffffff, 32'h3);
    hold_low <= 1'b1;
    bus(1'b1, OFF_FORCE, 32'h1, 4'hf);
    wait_core(1'b0);
    wait_core(1'b1);
    check("mode", MODE_BGND, mode_r);
    rd(OFF_OPT, 32'hffffffff, 32'h3);
    por(1'b0);
    check("mode", MODE_RUN, mode_r);
    check("vector", 32'hfffe, vector_addr_r);
    check("oe", 32'h0, pad_r.oe);
    check("pull_en", 32'h10, pad_r.pull_en);
    rd(OFF_OPT, 32'hffffffff, 32'h1);
    rd(OFF_PULL, 32'hffffffff, 32'h0);
    rd(OFF_SLEW, 32'hffffffff, {26'h0, SLEW_RST});
    rd(OFF_DRIVE, 32'hffffffff, 32'h0);
    rd(5'h18, 32'hffffffff, 32'h0);
    hold_low <= 1'b1;
    repeat (20) @(posedge core_clk);
    rd(OFF_STATUS, 32'h3, {30'h0, MODE_RUN});
    check("mode", MODE_RUN, mode_r);
    hold_low <= 1'b0;
    bus(1'b1, OFF_OPT, 32'h0, 4'h0);
    rd(OFF_OPT, 32'hffffffff, 32'h1);
    bus(1'b1, OFF_OPT, 32'h0, 4'hf);
    repeat (3) @(posedge core_clk);
    check("pull4", 32'h0, pad_r.pull_en[4]);
    repeat (24) pads();
    report_and_stop();
  end
endmodule
`default_nettype wire
